/* File: sim/cspid_motor_model.sv */
// motor stage with tachometer, speed given as offset binary
`timescale 1ns/10ps
`default_nettype none
module cspid_motor_model (
	// clock and stage enable
	input  wire logic              sys_clk,
	input  wire logic              outputEn,
	// shaft speed chosen by the bench
	input  wire logic signed [7:0] speedSet,
	// tachometer reading
	output logic             [7:0] fbSpeed
);
	// a stopped stage lets the shaft stand, which reads mid-scale
	always_ff @(posedge sys_clk)
		fbSpeed <= outputEn ? 8'h80 + speedSet : 8'h80;
endmodule // cspid_motor_model
`default_nettype wire

/* File: sim/cspid_top_chk.sv */
// port checker of the speed regulator and its bind
`timescale 1ns/10ps
`default_nettype none
module cspid_top_chk #(
	parameter int PERIOD_CYC    = 20,
	parameter int STARTUP_TICKS = 4,
	parameter int FAST_TICKS    = 4
) (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rst_b,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// faults
	input wire logic        overTemp,
	input wire logic        overVolt,
	input wire logic        underVolt,
	input wire logic        deadMan,
	input wire logic        emergencyStop,
	// outputs
	input wire logic [7:0]  motorPwr0,
	input wire logic [7:0]  motorPwr1,
	input wire logic        outputEn,
	input wire logic        statusLed
);
	localparam int LIM  = FAST_TICKS * PERIOD_CYC;
	localparam int DARK = (STARTUP_TICKS - 1) * PERIOD_CYC;
	logic fault;
	logic apbWr;
	logic stopSeen_ff;
	logic openMode_ff;
	logic ledPrev_ff;
	int   cyc_ff;
	int   sameCnt_ff;
	assign fault = overTemp | overVolt | underVolt | deadMan;
	assign apbWr = psel & penable & pwrite;
	// stop latch, open mode, age since reset and steady led run while latched
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			stopSeen_ff <= 1'b0;
			openMode_ff <= 1'b1;
			ledPrev_ff  <= 1'b0;
			cyc_ff      <= 0;
			sameCnt_ff  <= 0;
		end else begin
			stopSeen_ff <= stopSeen_ff | emergencyStop;
			ledPrev_ff  <= statusLed;
			if (apbWr && paddr == 12'h000)
				openMode_ff <= (pwdata[1:0] == 2'h0);
			if (cyc_ff < DARK)
				cyc_ff <= cyc_ff + 1;
			if (!stopSeen_ff || statusLed != ledPrev_ff)
				sameCnt_ff <= 0;
			else if (sameCnt_ff < LIM)
				sameCnt_ff <= sameCnt_ff + 1;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	bus_ready_a: assert property (pready && !pslverr)
		else $error("apb slave not ready");
	fault_off_a: assert property (fault |=> !outputEn)
		else $error("output on during fault");
	fault_led_a: assert property ((fault && !stopSeen_ff) [*2] |=> statusLed)
		else $error("led not steady during fault");
	out_resume_a: assert property (!fault && !emergencyStop && !stopSeen_ff |=> outputEn)
		else $error("output not enabled without fault");
	stop_hold_a: assert property (emergencyStop || stopSeen_ff |=> !outputEn)
		else $error("output on after stop");
	power_zero_a: assert property (!outputEn |-> motorPwr0 == 8'h00 && motorPwr1 == 8'h00)
		else $error("power while stage off");
	start_dark_a: assert property (cyc_ff < DARK && !fault && !stopSeen_ff |-> !statusLed)
		else $error("led active before startup");
	open_cmd_a: assert property (apbWr && paddr == 12'h008 && openMode_ff && outputEn && !fault
		&& !emergencyStop |-> ##2 motorPwr0 == $past(pwdata[7:0], 2))
		else $error("open loop power differs from command");
	stop_flash_a: assert property (stopSeen_ff |-> sameCnt_ff < LIM)
		else $error("led not flashing after stop");
	cover property (fault ##1 !outputEn);
	cover property (stopSeen_ff && statusLed);
	cover property (openMode_ff && motorPwr0 != 8'h00);
endmodule // cspid_top_chk
bind cspid_top cspid_top_chk #(.PERIOD_CYC(PERIOD_CYC), .STARTUP_TICKS(STARTUP_TICKS),
	.FAST_TICKS(FAST_TICKS)) u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .overTemp(overTemp), .overVolt(overVolt), .underVolt(underVolt),
	.deadMan(deadMan), .emergencyStop(emergencyStop), .motorPwr0(motorPwr0),
	.motorPwr1(motorPwr1), .outputEn(outputEn), .statusLed(statusLed));
`default_nettype wire

/* File: sim/test_closed_loop_speed_pid_with_fault_status.sv */
// self-checking bench of the speed regulator
`timescale 1ns/10ps
`default_nettype none
module test_closed_loop_speed_pid_with_fault_status;
	import cspid_pkg::*;
	localparam int PC = 20;
	logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, outputEn, statusLed, eStop;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [7:0] fb0, fb1, motorPwr0, motorPwr1, spd0, spd1;
	logic [3:0] flt;
	int num_errors, cmp_count, c0, c1, m, n, mx, dn;
	// device and tachometers
	cspid_top #(.PERIOD_CYC(PC), .STARTUP_TICKS(4), .LED_TICKS(2), .FAST_TICKS(4)) dut (
		.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fbSpeed0(fb0), .fbSpeed1(fb1), .overTemp(flt[0]), .overVolt(flt[1]),
		.underVolt(flt[2]), .deadMan(flt[3]), .emergencyStop(eStop), .motorPwr0(motorPwr0),
		.motorPwr1(motorPwr1), .outputEn(outputEn), .statusLed(statusLed));
	cspid_motor_model u_m0 (.sys_clk(sys_clk), .outputEn(outputEn), .speedSet(spd0), .fbSpeed(fb0));
	cspid_motor_model u_m1 (.sys_clk(sys_clk), .outputEn(outputEn), .speedSet(spd1), .fbSpeed(fb1));
	always #25 sys_clk = ~sys_clk;
	// apb master transfer
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// led changes over a window of cycles
	task automatic leds(input int w, output int c);
		logic l;
		c = 0;
		l = statusLed;
		repeat (w) begin
			@(posedge sys_clk);
			c += (statusLed !== l);
			l = statusLed;
		end
	endtask
	function automatic logic [7:0] sat(input int v);
		return v > 127 ? 8'h7F : v < -127 ? 8'h81 : v[7:0];
	endfunction
	// unit p gain, no d or i: power equals the saturated error, or the saturated command in open loop and on channel 1 in speed/position mode
	function automatic logic [7:0] expPwr(input int md, input int a, input int b, input int s,
		input int ch);
		int t;
		t = md == 2 ? (ch ? a - b : a + b) : (ch ? b : a);
		if (md == 0 || (md == 3 && ch))
			return sat(t);
		return sat(int'($signed(sat(t))) - s);
	endfunction
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#(40000 * 50);
		num_errors++;
		complete_run;
	end
	initial begin
		{sys_clk, psel, penable, pwrite, eStop, rst_b, flt, paddr, pwdata, spd0, spd1} = '0;
		n = $urandom(91968);
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		apb(0, 12'h000, 0);
		chk("ctrl reset", 0, q);
		apb(1, 12'h0FC, 32'hFFFF_FFFF);
		apb(0, 12'h0FC, 0);
		chk("unmapped", 0, q);
		for (int i = 0; i < 8; i++) begin
			c0 = i == 0 ? 127 : i == 1 ? -127 : int'($urandom_range(254)) - 127;
			c1 = int'($urandom_range(254)) - 127;
			spd0 <= 8'($urandom);
			apb(1, 12'h008, {16'h0000, c1[7:0], c0[7:0]});
			repeat (3) @(posedge sys_clk);
			chk("open pwr0", expPwr(0, c0, c1, 0, 0), motorPwr0);
			chk("open pwr1", expPwr(0, c0, c1, 0, 1), motorPwr1);
		end
		$display("test open loop done");
		apb(1, 12'h004, 32'h0000_0010);
		for (int md = 1; md < 4; md++) begin
			apb(1, 12'h000, md);
			for (int k = 0; k < 5; k++) begin
				c0 = k == 0 ? 127 : k == 1 ? -127 : int'($urandom_range(120)) - 60;
				c1 = k < 2 ? c0 : int'($urandom_range(120)) - 60;
				m = k == 0 ? -127 : k == 1 ? 127 : int'($urandom_range(120)) - 60;
				spd0 <= m[7:0];
				spd1 <= m[7:0];
				apb(1, 12'h008, {16'h0000, c1[7:0], c0[7:0]});
				repeat (3 * PC) @(posedge sys_clk);
				chk("loop pwr0", expPwr(md, c0, c1, m, 0), motorPwr0);
				chk("loop pwr1", expPwr(md, c0, c1, m, 1), motorPwr1);
			end
		end
		$display("test closed loop done");
		apb(1, 12'h000, 1);
		apb(1, 12'h004, 32'h0010_0000);
		spd0 <= 8'h00;
		apb(1, 12'h008, 0);
		repeat (3 * PC) @(posedge sys_clk);
		apb(1, 12'h008, 32'h0000_0020);
		mx = 0;
		repeat (4 * PC) begin
			@(posedge sys_clk);
			if (int'($signed(motorPwr0)) > mx)
				mx = int'($signed(motorPwr0));
		end
		chk("d kick", 32, mx);
		chk("d settle", 0, motorPwr0);
		$display("test differential done");
		for (int f = 0; f < 4; f++) begin
			flt <= 4'(1 << f);
			repeat (3) @(posedge sys_clk);
			chk("fault en", 0, outputEn);
			chk("fault led", 1, statusLed);
			flt <= 4'h0;
			repeat (3) @(posedge sys_clk);
			chk("clear en", 1, outputEn);
		end
		$display("test faults done");
		for (int md = 0; md < 4; md++) begin
			apb(1, 12'h000, md);
			repeat (32 * PC) @(posedge sys_clk);
			leds(32 * PC, n);
			chk("led edges", 2 * (md + 1), n);
		end
		$display("test led patterns done");
		apb(1, 12'h000, 1);
		apb(1, 12'h004, 32'h0000_1000);
		apb(1, 12'h008, 32'h0000_0010);
		dn = 0;
		repeat (30 * PC) begin
			mx = int'($signed(motorPwr0));
			@(posedge sys_clk);
			dn += int'($signed(motorPwr0)) < mx;
		end
		chk("ramp drops", 0, dn);
		chk("ramp top", 8'h7F, motorPwr0);
		$display("test ramp done");
		eStop <= 1'b1;
		repeat (3) @(posedge sys_clk);
		eStop <= 1'b0;
		repeat (5 * PC) @(posedge sys_clk);
		chk("stop en", 0, outputEn);
		leds(8 * PC, n);
		chk("stop flash", 4, n);
		rst_b <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk("reset en", 1, outputEn);
		$display("test emergency stop done");
		complete_run;
	end
endmodule // test_closed_loop_speed_pid_with_fault_status
`default_nettype wire

/* File: src/cspid_map.svh */
// register map, field layout and timing constants of the speed regulator
`ifndef CSPID_MAP_SVH
`define CSPID_MAP_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define CSPID_CTRL_OFS     12'h000
`define CSPID_GAIN_OFS     12'h004
`define CSPID_CMD_OFS      12'h008
`define CSPID_STAT_OFS     12'h00C
`define CSPID_PWR_OFS      12'h010

// ----------------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------------
`define CSPID_CTRL_MODE_LSB  0
`define CSPID_CTRL_MODE_W    2
`define CSPID_CTRL_RESET     2'h0
`define CSPID_GAIN_RESET     24'h00_0000
`define CSPID_ZERO_SPEED     8'h80
`define CSPID_PWR_MAX        8'h7F
`define CSPID_PWR_MIN        8'h81
`define CSPID_INT_MAX        16'h3F80
`define CSPID_INT_MIN        16'hC080

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CSPID_CLK_HZ         20000000
`define CSPID_PERIOD_MS      16
`define CSPID_STARTUP_MS     1000
`define CSPID_LED_STEP_MS    128
`define CSPID_FAST_MS        64

`endif

/* File: src/cspid_pid_term.sv */
// one channel pid step: error, p, i, d terms and saturation
`timescale 1ns/10ps
`default_nettype none
`include "cspid_map.svh"
module cspid_pid_term
	import cspid_pkg::*;
#(
	parameter int DW = 8
) (
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst_b,
	// control
	input  wire logic                 stepEn,
	input  wire logic signed [DW-1:0] cmdSpeed,
	input  wire logic signed [DW-1:0] measSpeed,
	input  wire logic        [7:0]    gainP,
	input  wire logic        [7:0]    gainI,
	input  wire logic        [7:0]    gainD,
	// result
	output logic signed [DW-1:0]      pidOut
);
	typedef struct packed {
		logic signed [DW:0]   prevErr;
		logic signed [15:0]   integ;
		logic signed [DW-1:0] out;
	} cspid_term_t;

	cspid_term_t st_ff;
	cspid_term_t nxt_st;

	// combinational pid step, gains are unsigned q4.4
	always_comb begin
		logic signed [DW:0]  err;
		logic signed [DW+1:0] dErr;
		logic signed [23:0]  sum;
		logic signed [23:0]  iSum;
		err  = '0;
		dErr = '0;
		sum  = '0;
		iSum = '0;
		nxt_st = st_ff;
		if (stepEn) begin
			err  = (DW+1)'(cmdSpeed) - (DW+1)'(measSpeed);
			dErr = (DW+2)'(err) - (DW+2)'(st_ff.prevErr);
			iSum = 24'(st_ff.integ) + 24'(err) * $signed({1'b0, gainI});
			// clamp accumulator against windup
			if (iSum > 24'(signed'(`CSPID_INT_MAX)))
				nxt_st.integ = `CSPID_INT_MAX;
			else if (iSum < 24'(signed'(`CSPID_INT_MIN)))
				nxt_st.integ = `CSPID_INT_MIN;
			else
				nxt_st.integ = iSum[15:0];
			sum = 24'(err) * $signed({1'b0, gainP})
				+ 24'(dErr) * $signed({1'b0, gainD})
				+ 24'(nxt_st.integ);
			sum = sum >>> 4;
			// saturate to full signed power range, so a stuck error ramps to 100 %
			if (sum > 24'(signed'(`CSPID_PWR_MAX)))
				nxt_st.out = `CSPID_PWR_MAX;
			else if (sum < -24'(signed'(`CSPID_PWR_MAX)))
				nxt_st.out = `CSPID_PWR_MIN;
			else
				nxt_st.out = sum[DW-1:0];
			nxt_st.prevErr = err;
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign pidOut = st_ff.out;
endmodule // cspid_pid_term
`default_nettype wire

/* File: src/cspid_pkg.sv */
// types shared by the speed regulator files
package cspid_pkg;
	// ------------------------------------------------------------------------
	// operating modes
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		CSPID_OPEN,
		CSPID_SEPARATE,
		CSPID_MIXED,
		CSPID_SPD_POS
	} cspid_mode_t;
	// ------------------------------------------------------------------------
	// loop sequencer
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		CSPID_IDLE,
		CSPID_CH0,
		CSPID_CH1
	} cspid_seq_t;
endpackage : cspid_pkg

/* File: src/cspid_top.sv */
// two channel closed loop speed regulator with fault and status led
`timescale 1ns/10ps
`default_nettype none
`include "cspid_map.svh"
// Overview of operation
// - sample speed each 16 ms, error is command minus speed
// - proportional term is error times p gain
// - differential term from error change times d gain
// - integral accumulates error scaled by i gain
// - feedback mid-scale is zero, signed plus/minus 127
// - one gain set shared by both channels
// - open loop drives power from command directly
// - no feedback loss detection, power ramps to limit
// - mode flash pattern starts one second after reset
// - recoverable fault turns output off, led steady
// - faults cleared re-enable output, normal flashing
// - emergency stop latches off, led flashes rapidly
// - three speed configurations: separate, mixed, speed/position
module cspid_top
	import cspid_pkg::*;
#(
	parameter int DW            = 8,
	parameter int PERIOD_CYC    = `CSPID_CLK_HZ / 1000 * `CSPID_PERIOD_MS,
	parameter int STARTUP_TICKS = `CSPID_STARTUP_MS / `CSPID_PERIOD_MS,
	parameter int LED_TICKS     = `CSPID_LED_STEP_MS / `CSPID_PERIOD_MS,
	parameter int FAST_TICKS    = `CSPID_FAST_MS / `CSPID_PERIOD_MS
) (
	// clock and reset
	input  wire logic          sys_clk,
	input  wire logic          rst_b,
	// apb slave
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [11:0]   paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	// speed feedback, unsigned 0 = full reverse
	input  wire logic [DW-1:0] fbSpeed0,
	input  wire logic [DW-1:0] fbSpeed1,
	// fault inputs
	input  wire logic          overTemp,
	input  wire logic          overVolt,
	input  wire logic          underVolt,
	input  wire logic          deadMan,
	input  wire logic          emergencyStop,
	// power stage
	output logic signed [DW-1:0] motorPwr0,
	output logic signed [DW-1:0] motorPwr1,
	output logic                 outputEn,
	// status
	output logic                 statusLed
);
	localparam int TW = 32;

	typedef struct packed {
		logic [TW-1:0]         divCnt;
		logic [7:0]            startCnt;
		logic                  started;
		logic [7:0]            ledCnt;
		logic [3:0]            ledStep;
		logic [7:0]            fastCnt;
		logic                  estopLatch;
		logic [1:0]            mode;
		logic [23:0]           gains;
		logic signed [DW-1:0]  cmd0;
		logic signed [DW-1:0]  cmd1;
		logic signed [DW-1:0]  pwr0;
		logic signed [DW-1:0]  pwr1;
		logic                  outEn;
		logic                  led;
		logic [31:0]           rdata;
	} cspid_st_t;

	cspid_st_t st_ff;
	cspid_st_t nxt_st;

	// --------------------------------------------------------------------
	// feedback conversion and pid channels
	// --------------------------------------------------------------------
	logic                  tick;
	logic signed [DW-1:0]  meas0;
	logic signed [DW-1:0]  meas1;
	logic signed [DW-1:0]  pid0;
	logic signed [DW-1:0]  pid1;
	logic signed [DW-1:0]  mixA;
	logic signed [DW-1:0]  mixB;
	logic                  anyFault;
	logic                  apbWr;
	logic                  apbRd;

	// offset binary to signed, mid-scale reads as zero
	function automatic logic signed [DW-1:0] toSigned(input logic [DW-1:0] raw);
		toSigned = signed'(raw ^ {1'b1, {(DW-1){1'b0}}});
	endfunction

	// saturating add used for mixed steering
	function automatic logic signed [DW-1:0] satAdd(input logic signed [DW-1:0] a,
		input logic signed [DW-1:0] b);
		logic signed [DW:0] s;
		s = (DW+1)'(a) + (DW+1)'(b);
		if (s > (DW+1)'(signed'(`CSPID_PWR_MAX)))
			satAdd = `CSPID_PWR_MAX;
		else if (s < -(DW+1)'(signed'(`CSPID_PWR_MAX)))
			satAdd = `CSPID_PWR_MIN;
		else
			satAdd = s[DW-1:0];
	endfunction

	assign tick  = (st_ff.divCnt == TW'(PERIOD_CYC - 1));
	assign meas0 = toSigned(fbSpeed0);
	assign meas1 = toSigned(fbSpeed1);
	// mixed mode: cmd0 is throughput, cmd1 is steering
	assign mixA  = satAdd(st_ff.cmd0, st_ff.cmd1);
	assign mixB  = satAdd(st_ff.cmd0, -st_ff.cmd1);

	// both channels run from one shared gain word
	cspid_pid_term #(.DW(DW)) uPid0 (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.stepEn    (tick),
		.cmdSpeed  ((st_ff.mode == 2'(CSPID_MIXED)) ? mixA : st_ff.cmd0),
		.measSpeed (meas0),
		.gainP     (st_ff.gains[7:0]),
		.gainI     (st_ff.gains[15:8]),
		.gainD     (st_ff.gains[23:16]),
		.pidOut    (pid0)
	);
	cspid_pid_term #(.DW(DW)) uPid1 (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.stepEn    (tick),
		.cmdSpeed  ((st_ff.mode == 2'(CSPID_MIXED)) ? mixB : st_ff.cmd1),
		.measSpeed (meas1),
		.gainP     (st_ff.gains[7:0]),
		.gainI     (st_ff.gains[15:8]),
		.gainD     (st_ff.gains[23:16]),
		.pidOut    (pid1)
	);

	// --------------------------------------------------------------------
	// apb decode helpers
	// --------------------------------------------------------------------
	assign apbWr    = psel && penable && pwrite;
	assign apbRd    = psel && !penable && !pwrite;
	assign anyFault = overTemp || overVolt || underVolt || deadMan;

	// per-mode flash sequence, one bit per led step
	function automatic logic modePattern(input logic [1:0] m, input logic [3:0] s);
		logic [15:0] p;
		case (m)
			2'(CSPID_OPEN):     p = 16'h00FF;
			2'(CSPID_SEPARATE): p = 16'h0033;
			2'(CSPID_MIXED):    p = 16'h0333;
			default:            p = 16'h3333;
		endcase
		modePattern = p[s];
	endfunction

	// --------------------------------------------------------------------
	// next state
	// --------------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		// control period divider
		nxt_st.divCnt = tick ? '0 : st_ff.divCnt + TW'(1);
		// startup delay before flashing
		if (tick && !st_ff.started) begin
			if (st_ff.startCnt == 8'(STARTUP_TICKS - 1))
				nxt_st.started = 1'b1;
			else
				nxt_st.startCnt = st_ff.startCnt + 8'h01;
		end
		// led step timer
		if (tick) begin
			if (st_ff.ledCnt >= 8'(LED_TICKS - 1)) begin
				nxt_st.ledCnt  = '0;
				nxt_st.ledStep = st_ff.ledStep + 4'h1;
			end else
				nxt_st.ledCnt = st_ff.ledCnt + 8'h01;
		end
		// fast flash timer, kept apart so the stop blink never depends on the led step
		if (tick) begin
			if (st_ff.fastCnt >= 8'(FAST_TICKS - 1))
				nxt_st.fastCnt = '0;
			else
				nxt_st.fastCnt = st_ff.fastCnt + 8'h01;
		end
		// emergency stop latches until reset
		if (emergencyStop)
			nxt_st.estopLatch = 1'b1;
		// output enable follows faults and latch
		nxt_st.outEn = !anyFault && !nxt_st.estopLatch;
		// power update once per period, open loop every cycle
		if (!nxt_st.outEn) begin
			nxt_st.pwr0 = '0;
			nxt_st.pwr1 = '0;
		end else if (st_ff.mode == 2'(CSPID_OPEN)) begin
			nxt_st.pwr0 = st_ff.cmd0;
			nxt_st.pwr1 = st_ff.cmd1;
		end else if (tick) begin
			nxt_st.pwr0 = pid0;
			nxt_st.pwr1 = (st_ff.mode == 2'(CSPID_SPD_POS)) ? st_ff.cmd1 : pid1;
		end
		// led pattern priority: latch, fault, normal
		if (st_ff.estopLatch)
			nxt_st.led = (st_ff.fastCnt < 8'(FAST_TICKS / 2));
		else if (anyFault)
			nxt_st.led = 1'b1;
		else if (st_ff.started)
			nxt_st.led = modePattern(st_ff.mode, st_ff.ledStep);
		else
			nxt_st.led = 1'b0;
		// register writes
		if (apbWr) begin
			if (paddr == `CSPID_CTRL_OFS)
				nxt_st.mode = pwdata[`CSPID_CTRL_MODE_LSB +: `CSPID_CTRL_MODE_W];
			else if (paddr == `CSPID_GAIN_OFS)
				nxt_st.gains = pwdata[23:0];
			else if (paddr == `CSPID_CMD_OFS) begin
				nxt_st.cmd0 = pwdata[DW-1:0];
				nxt_st.cmd1 = pwdata[DW+7:8];
			end
		end
		// read data captured in setup phase
		if (apbRd) begin
			if (paddr == `CSPID_CTRL_OFS)
				nxt_st.rdata = {30'h0000_0000, st_ff.mode};
			else if (paddr == `CSPID_GAIN_OFS)
				nxt_st.rdata = {8'h00, st_ff.gains};
			else if (paddr == `CSPID_CMD_OFS)
				nxt_st.rdata = {16'h0000, st_ff.cmd1, st_ff.cmd0};
			else if (paddr == `CSPID_STAT_OFS)
				nxt_st.rdata = {24'h00_0000, st_ff.started, st_ff.led, st_ff.outEn,
					st_ff.estopLatch, deadMan, underVolt, overVolt, overTemp};
			else if (paddr == `CSPID_PWR_OFS)
				nxt_st.rdata = {16'h0000, st_ff.pwr1, st_ff.pwr0};
			else
				nxt_st.rdata = '0;
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff       <= '0;
			st_ff.mode  <= `CSPID_CTRL_RESET;
			st_ff.gains <= `CSPID_GAIN_RESET;
		end else
			st_ff <= nxt_st;
	end

	// --------------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------------
	assign pready    = 1'b1;
	assign pslverr   = 1'b0;
	assign prdata    = st_ff.rdata;
	assign motorPwr0 = st_ff.pwr0;
	assign motorPwr1 = st_ff.pwr1;
	assign outputEn  = st_ff.outEn;
	assign statusLed = st_ff.led;
endmodule // cspid_top
`default_nettype wire
